// File: rtl/subdp_regs.svh
// Constants of the subtract datapath
`ifndef SUBDP_REGS_SVH
`define SUBDP_REGS_SVH
`define SUBDP_FILE_OPC 6'h02
`define SUBDP_FILE_OPC_MSB 13
`define SUBDP_FILE_OPC_LSB 8
`define SUBDP_LIT_OPC 5'h1E
`define SUBDP_LIT_OPC_MSB 13
`define SUBDP_LIT_OPC_LSB 9
`define SUBDP_DEST_BIT 7
`define SUBDP_FADDR_MSB 6
`define SUBDP_LIT_MSB 7
`define SUBDP_W_RESET 8'h00
`define SUBDP_FLAG_RESET 1'h0
`endif

// File: rtl/subdp_pkg.sv
// Types of the subtract datapath
package subdp_pkg;
  typedef enum logic [1:0] {subdp_none, subtract_from_literal_op, subtract_from_file_op} subdp_op_t;
endpackage : subdp_pkg

// File: rtl/subdp_alu.sv
// Eight-bit subtractor with flag generation
`timescale 1ns/100ps
module subdp_alu #(
  parameter int WIDTH = 8
) (
  // Operands
  input wire logic [WIDTH-1:0] minuend,
  input wire logic [WIDTH-1:0] subtrahend,
  // Results
  output logic [WIDTH-1:0] difference,
  output logic carry,
  output logic digit_carry,
  output logic zero
);
  // ===========================================================
  // Two's complement add of inverted subtrahend
  logic [WIDTH:0] full_sum;
  logic [4:0] low_sum;
  assign full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + {{WIDTH{1'b0}}, 1'b1};
  assign low_sum = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
  assign difference = full_sum[WIDTH-1:0];
  assign carry = full_sum[WIDTH];
  assign digit_carry = low_sum[4];
  assign zero = (full_sum[WIDTH-1:0] == '0);
endmodule : subdp_alu

// File: rtl/subdp_core.sv
// Subtract instruction decode and writeback
// Overview of operation
// - Literal subtract: literal minus W into W
// - Decode file subtract; file minus W
// - Destination clear: result to W only
// - Destination set: result to file register
// - Carry, digit carry, zero updated; carry=no borrow
`timescale 1ns/100ps
`include "subdp_regs.svh"
module subdp_core import subdp_pkg::*; #(
  parameter int WIDTH = 8,
  parameter int FADDR_W = 7
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Instruction issue
  input wire logic instr_valid,
  input wire logic [13:0] instr_word,
  // File register read data for addressed register
  input wire logic [WIDTH-1:0] file_rdata,
  // File register write port
  output logic file_we,
  output logic [FADDR_W-1:0] file_waddr,
  output logic [WIDTH-1:0] file_wdata,
  // Working register and flags
  output logic [WIDTH-1:0] w_reg,
  output logic carry_flag,
  output logic digit_carry_flag,
  output logic zero_flag,
  // File address for reading
  output logic [FADDR_W-1:0] file_raddr
);
  // ===========================================================
  // Decode
  function automatic subdp_op_t decode_op(input logic [13:0] word);
    if (word[`SUBDP_FILE_OPC_MSB:`SUBDP_FILE_OPC_LSB] == `SUBDP_FILE_OPC)
      return subtract_from_file_op;
    else if (word[`SUBDP_LIT_OPC_MSB:`SUBDP_LIT_OPC_LSB] == `SUBDP_LIT_OPC)
      return subtract_from_literal_op;
    else
      return subdp_none;
  endfunction : decode_op

  subdp_op_t op;
  logic dest_file;
  logic [WIDTH-1:0] minuend;
  logic [WIDTH-1:0] diff;
  logic c_out;
  logic dc_out;
  logic z_out;
  logic do_lit;
  logic do_file;
  assign op = instr_valid ? decode_op(instr_word) : subdp_none;
  assign do_lit = (op == subtract_from_literal_op);
  assign do_file = (op == subtract_from_file_op);
  assign dest_file = instr_word[`SUBDP_DEST_BIT];
  assign file_raddr = instr_word[`SUBDP_FADDR_MSB:0];
  assign minuend = do_file ? file_rdata : instr_word[`SUBDP_LIT_MSB:0];

  // ===========================================================
  // Arithmetic
  subdp_alu #(.WIDTH(WIDTH)) u_alu (
    .minuend(minuend),
    .subtrahend(w_reg),
    .difference(diff),
    .carry(c_out),
    .digit_carry(dc_out),
    .zero(z_out)
  );

  // ===========================================================
  // Writeback
  logic next_w_load;
  logic next_file_we;
  logic next_flag_load;
  assign next_w_load = do_lit || (do_file && !dest_file);
  assign next_file_we = do_file && dest_file;
  assign next_flag_load = do_lit || do_file;

  // ===========================================================
  // Working register
  always_ff @(posedge clock) begin
    if (reset) begin
      w_reg <= `SUBDP_W_RESET;
    end else if (next_w_load) begin
      w_reg <= diff;
    end
  end

  // ===========================================================
  // Status flags
  always_ff @(posedge clock) begin
    if (reset) begin
      carry_flag <= `SUBDP_FLAG_RESET;
      digit_carry_flag <= `SUBDP_FLAG_RESET;
      zero_flag <= `SUBDP_FLAG_RESET;
    end else if (next_flag_load) begin
      carry_flag <= c_out;
      digit_carry_flag <= dc_out;
      zero_flag <= z_out;
    end
  end

  // ===========================================================
  // File register write port
  always_ff @(posedge clock) begin
    if (reset) begin
      file_we <= 1'b0;
      file_waddr <= '0;
      file_wdata <= '0;
    end else begin
      file_we <= next_file_we;
      file_waddr <= file_raddr;
      file_wdata <= diff;
    end
  end

  // ===========================================================
  // Checks
  property p_lit_w;
    @(posedge clock) disable iff (reset)
      do_lit |=> (w_reg == $past(instr_word[7:0]) - $past(w_reg));
  endproperty
  a_lit_w: assert property (p_lit_w) else $error("literal subtract result wrong");
  property p_file_w;
    @(posedge clock) disable iff (reset)
      (do_file && !dest_file) |=> (w_reg == $past(file_rdata) - $past(w_reg)) && !file_we;
  endproperty
  a_file_w: assert property (p_file_w) else $error("file subtract to W wrong");
  property p_file_f;
    @(posedge clock) disable iff (reset)
      (do_file && dest_file) |=> file_we && (file_wdata == $past(file_rdata) - $past(w_reg))
        && $stable(w_reg) && (file_waddr == $past(instr_word[6:0]));
  endproperty
  a_file_f: assert property (p_file_f) else $error("file subtract to file wrong");
  property p_decode;
    @(posedge clock) disable iff (reset)
      (instr_valid && (instr_word[`SUBDP_FILE_OPC_MSB:`SUBDP_FILE_OPC_LSB] == `SUBDP_FILE_OPC))
        |=> (file_we == $past(instr_word[`SUBDP_DEST_BIT]));
  endproperty
  a_decode: assert property (p_decode) else $error("file subtract not decoded");
  property p_carry;
    @(posedge clock) disable iff (reset)
      (do_lit || do_file) |=> carry_flag == ($past(minuend) >= $past(w_reg));
  endproperty
  a_carry: assert property (p_carry) else $error("carry wrong");
  property p_dc;
    @(posedge clock) disable iff (reset)
      (do_lit || do_file) |=> digit_carry_flag == ($past(minuend[3:0]) >= $past(w_reg[3:0]));
  endproperty
  a_dc: assert property (p_dc) else $error("digit carry wrong");
  property p_zero;
    @(posedge clock) disable iff (reset)
      (do_lit || do_file) |=> zero_flag == ($past(minuend) == $past(w_reg));
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_idle;
    @(posedge clock) disable iff (reset)
      !(do_lit || do_file) |=> $stable(w_reg) && $stable(carry_flag) && $stable(digit_carry_flag)
        && $stable(zero_flag) && !file_we;
  endproperty
  a_idle: assert property (p_idle) else $error("state changed without subtract");

  property p_refused;
    @(posedge clock) disable iff (reset)
      (instr_valid && !next_flag_load) |=> $stable(w_reg) && $stable(zero_flag) && !file_we;
  endproperty
  a_refused: assert property (p_refused) else $error("non-subtract word changed state");

  property p_lit_no_we;
    @(posedge clock) disable iff (reset)
      do_lit |=> !file_we;
  endproperty
  a_lit_no_we: assert property (p_lit_no_we) else $error("literal subtract wrote a file register");

  property p_we_pulse;
    @(posedge clock) disable iff (reset)
      file_we |-> $past(next_file_we);
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("file write without file subtract");

  property p_w_source;
    @(posedge clock) disable iff (reset)
      $changed(w_reg) |-> $past(next_w_load);
  endproperty
  a_w_source: assert property (p_w_source) else $error("working register changed without load");

  property p_flag_source;
    @(posedge clock) disable iff (reset)
      ($changed(carry_flag) || $changed(digit_carry_flag) || $changed(zero_flag)) |-> $past(next_flag_load);
  endproperty
  a_flag_source: assert property (p_flag_source) else $error("flags changed without subtract");

  property p_wdata_w;
    @(posedge clock) disable iff (reset)
      next_w_load |=> (w_reg == file_wdata);
  endproperty
  a_wdata_w: assert property (p_wdata_w) else $error("working register differs from difference");

  property p_zero_data;
    @(posedge clock) disable iff (reset)
      next_flag_load |=> (zero_flag == (file_wdata == '0));
  endproperty
  a_zero_data: assert property (p_zero_data) else $error("zero flag disagrees with difference");

  property p_cov_lit;
    @(posedge clock) disable iff (reset) do_lit;
  endproperty
  c_lit: cover property (p_cov_lit);
  property p_cov_ff;
    @(posedge clock) disable iff (reset) do_file && dest_file;
  endproperty
  c_ff: cover property (p_cov_ff);
  property p_cov_borrow;
    @(posedge clock) disable iff (reset) do_file && !c_out;
  endproperty
  c_borrow: cover property (p_cov_borrow);
  property p_cov_zero;
    @(posedge clock) disable iff (reset) do_lit && z_out;
  endproperty
  c_zero: cover property (p_cov_zero);
  property p_cov_back;
    @(posedge clock) disable iff (reset) do_lit ##1 do_lit;
  endproperty
  c_back: cover property (p_cov_back);
endmodule : subdp_core

// File: verification/tb_subtract_instruction_datapath.sv
// Self-checking bench for the subtract datapath core
`timescale 1ns/100ps
module tb_subtract_instruction_datapath;
  // ==========================================
  // Stimulus and observed signals
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic instr_valid = 1'b0;
  logic [13:0] instr_word = 14'h0000;
  logic [7:0] file_rdata = 8'h00;
  logic file_we, carry_flag, digit_carry_flag, zero_flag;
  logic [6:0] file_waddr, file_raddr;
  logic [7:0] file_wdata, w_reg, ew;
  int fail_count = 0;
  int check_count = 0;
  subdp_core dut_u (.clock(clock), .reset(reset), .instr_valid(instr_valid), .instr_word(instr_word),
    .file_rdata(file_rdata), .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata),
    .w_reg(w_reg), .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag),
    .file_raddr(file_raddr));
  initial begin
    forever #12.5 clock = ~clock;
  end
  // ==========================================
  // Shared tasks
  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task issue(input logic [13:0] word, input logic [7:0] rd);
    @(posedge clock);
    instr_valid <= 1'b1;
    instr_word <= word;
    file_rdata <= rd;
    @(posedge clock);
    instr_valid <= 1'b0;
    #1;
  endtask : issue
  task chk_sub(input logic [7:0] a, input logic [7:0] b);
    chk("carry", {7'h00, a >= b}, {7'h00, carry_flag});
    chk("digit carry", {7'h00, a[3:0] >= b[3:0]}, {7'h00, digit_carry_flag});
    chk("zero", {7'h00, a == b}, {7'h00, zero_flag});
  endtask : chk_sub
  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  // ==========================================
  // Scenarios
  task t_lit;
    logic [7:0] k [6];
    logic [7:0] old;
    k = '{8'h01, 8'h02, 8'h01, 8'h10, 8'h05, 8'h00};
    for (int i = 0; i < 6; i++) begin
      old = ew;
      issue({5'h1E, i[0], k[i]}, 8'h00);
      ew = k[i] - old;
      chk("w literal", ew, w_reg);
      chk_sub(k[i], old);
    end
    $display("literal test done");
  endtask : t_lit
  task t_file;
    logic [7:0] old;
    old = ew;
    issue(14'h0215, 8'h80);
    chk("read address", 8'h15, {1'b0, file_raddr});
    ew = 8'h80 - old;
    chk("w file", ew, w_reg);
    chk("write strobe", 8'h00, {7'h00, file_we});
    chk_sub(8'h80, old);
    issue(14'h02FF, 8'h03);
    chk("write strobe", 8'h01, {7'h00, file_we});
    chk("write address", 8'h7F, {1'b0, file_waddr});
    chk("write data", 8'h03 - ew, file_wdata);
    chk("w kept", ew, w_reg);
    chk_sub(8'h03, ew);
    @(posedge clock);
    #1;
    chk("strobe end", 8'h00, {7'h00, file_we});
    $display("file test done");
  endtask : t_file
  task t_back;
    logic [7:0] old;
    @(posedge clock);
    instr_valid <= 1'b1;
    instr_word <= 14'h3C40;
    @(posedge clock);
    instr_word <= 14'h3D50;
    #1;
    ew = 8'h40 - ew;
    chk("w first", ew, w_reg);
    @(posedge clock);
    instr_valid <= 1'b0;
    #1;
    chk("w second", 8'h50 - ew, w_reg);
    chk_sub(8'h50, ew);
    old = ew;
    ew = 8'h50 - ew;
    issue(14'h3E55, 8'h00);
    issue(14'h0755, 8'h11);
    @(posedge clock);
    instr_word <= 14'h3C99;
    @(posedge clock);
    #1;
    chk("w ignored", ew, w_reg);
    chk("no strobe", 8'h00, {7'h00, file_we});
    chk_sub(8'h50, old);
    $display("order test done");
  endtask : t_back
  task t_reset;
    @(posedge clock);
    reset <= 1'b1;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    instr_valid <= 1'b1;
    instr_word <= 14'h0215;
    file_rdata <= 8'h02;
    #1;
    chk("w reset", 8'h00, w_reg);
    chk("carry reset", 8'h00, {7'h00, carry_flag});
    chk("digit carry reset", 8'h00, {7'h00, digit_carry_flag});
    chk("zero reset", 8'h00, {7'h00, zero_flag});
    chk("strobe reset", 8'h00, {7'h00, file_we});
    chk("write address reset", 8'h00, {1'b0, file_waddr});
    chk("write data reset", 8'h00, file_wdata);
    @(posedge clock);
    instr_word <= 14'h028A;
    file_rdata <= 8'h03;
    #1;
    chk("w after reset", 8'h02, w_reg);
    chk("write strobe", 8'h00, {7'h00, file_we});
    chk_sub(8'h02, 8'h00);
    @(posedge clock);
    instr_valid <= 1'b0;
    #1;
    chk("write data", 8'h01, file_wdata);
    chk("write address", 8'h0A, {1'b0, file_waddr});
    chk("write strobe", 8'h01, {7'h00, file_we});
    chk("w kept", 8'h02, w_reg);
    chk_sub(8'h03, 8'h02);
    ew = 8'h02;
    $display("reset test done");
  endtask : t_reset
  // ==========================================
  // Main sequence and watchdog
  initial begin
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    #1;
    ew = 8'h00;
    chk("w reset", 8'h00, w_reg);
    t_lit();
    t_file();
    t_back();
    t_reset();
    tally_and_finish();
  end
  initial begin
    #25000;
    fail_count++;
    tally_and_finish();
  end
endmodule : tb_subtract_instruction_datapath
